// File: rtl/rfm_defines.svh
// Constants of the reference failover monitor: select codes, timing, tuning.
// Assumes a 100 MHz system clock; included by bare name from rtl/.
`ifndef RFM_DEFINES_SVH
`define RFM_DEFINES_SVH

// ****************************************************************
// Ratio select codes
// ****************************************************************
`define RFM_SEL_BYPASS      2'h0
`define RFM_SEL_HALF        2'h1
`define RFM_SEL_DOUBLE      2'h2
`define RFM_SEL_SIX         2'h3

// ****************************************************************
// Ratio numerator and denominator per code (REF:XTAL = num/den)
// ****************************************************************
`define RFM_NUM_HALF        3'h1
`define RFM_DEN_HALF        2'h2
`define RFM_NUM_DOUBLE      3'h2
`define RFM_DEN_DOUBLE      2'h1
`define RFM_NUM_SIX         3'h6
`define RFM_DEN_SIX         2'h1

// ****************************************************************
// Timing
// ****************************************************************
`define RFM_CLK_PERIOD_NS   10
`define RFM_FAIL_PERIODS    2
`define RFM_RECOVER_PERIODS 12
`define RFM_EXTRA_NS        25
// Longest extra time rounds down, least extra time rounds up, at least one cycle
`define RFM_FAIL_EXTRA_CYC  (((`RFM_EXTRA_NS / `RFM_CLK_PERIOD_NS) < 1) ? 1 : \
                             (`RFM_EXTRA_NS / `RFM_CLK_PERIOD_NS))
`define RFM_REC_EXTRA_CYC   ((`RFM_EXTRA_NS + `RFM_CLK_PERIOD_NS - 1) / `RFM_CLK_PERIOD_NS)

// ****************************************************************
// Tuning of the capacitor array
// ****************************************************************
`define RFM_CAPTURE_PPM     300
`define RFM_PPM_SCALE       1000000
`define RFM_TUNE_RESET      8'h80
`define RFM_TUNE_MAX        8'hFF
`define RFM_TUNE_MIN        8'h00

`endif

// File: rtl/rfm_pkg.sv
// Types of the reference failover monitor.
// Used by rfm_monitor; no state of its own.
package rfm_pkg;

  typedef enum logic [1:0] {RFM_FAIL, RFM_RECOVER, RFM_VALID} rfm_state_t;

  typedef struct packed {
    logic [2:0] num;
    logic [1:0] den;
  } rfm_ratio_t;

  typedef struct packed {
    logic bypass;
    logic tracking;
    logic ref_good;
    logic xtal_ok;
  } rfm_status_t;

  typedef struct packed {
    logic        edge_seen;
    logic [15:0] period;
    logic [15:0] gap;
  } rfm_meter_t;

endpackage : rfm_pkg

// File: rtl/rfm_edge_meter.sv
// Edge meter: synchronises one pin and measures the spacing of its rising edges.
// Assumes sys_clk is at least twice as fast as the measured clock.
`timescale 1ns/1ps
`default_nettype none

module rfm_edge_meter
  import rfm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       pin_in,
  output rfm_meter_t      meter
);

  logic        sync_a;
  logic        sync_b;
  logic        last;
  logic [15:0] gap;
  logic [15:0] period;
  logic [15:0] next_gap;
  logic [15:0] next_period;
  logic        rise;

  // ****************************************************************
  // Synchroniser and edge detect
  // ****************************************************************
  assign rise = sync_b && !last;

  always_comb
  begin
    next_period = period;
    if (rise)
    begin
      next_gap    = 16'h0000;
      next_period = gap + 16'h0001;
    end
    else if (gap != 16'hFFFF)
      next_gap = gap + 16'h0001;
    else
      next_gap = gap;   // Saturate so a stopped clock stays stopped
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
      gap    <= 16'hFFFF;
      period <= 16'h0000;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      last   <= sync_b;
      gap    <= next_gap;
      period <= next_period;
    end
  end

  // One assignment for the whole struct: a variable takes a single continuous driver
  assign meter = '{edge_seen: rise, period: period, gap: gap};

endmodule // rfm_edge_meter

`default_nettype wire

// File: rtl/rfm_monitor.sv
// Reference failover monitor: reference selection, range check, valid flag
// and capacitor array tuning of the crystal oscillator.
// Assumes reference, crystal and feedback pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "rfm_defines.svh"

// How it works
// - Select pin high routes the first reference, low routes the second.
// - Ratio code 00 bypasses both the loop and the tuned oscillator.
// - Codes 01, 10, 11 give reference-to-crystal ratios 1/2, 2 and 6.
// - Oscillator is tuned only while the divided reference is in capture range.
// - Valid flag high means a valid reference, low means failure.
// - Divided reference outside capture range drives the valid flag low.
// - Reference back in range clears the failure indication.
// - Stopped reference freezes tuning at last setting and flags failure.
// - Failure shown within two crystal periods plus 25 ns, or within BYPASS_TIMEOUT cycles in bypass.
// - Failure held at least twelve crystal periods plus 25 ns after recovery.
// - Capacitor array pulls the crystal about 300 ppm either way.
// - Tuning resumes by itself once the reference returns.
// - Loop is always clocked by the tuned oscillator, never by a reference.
module rfm_monitor
  import rfm_pkg::*;
#(
  parameter int unsigned XTAL_TIMEOUT   = 64,
  parameter int unsigned BYPASS_TIMEOUT = 1024
)
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ref_first,
  input  wire logic        ref_second,
  input  wire logic        reference_select,
  input  wire logic [1:0]  ratio_select,
  input  wire logic        crystal_input,
  input  wire logic        feedback_input,
  input  wire logic        loop_clock,
  output logic             loop_input_clock,
  output logic [1:0]       first_bank_outputs,
  output logic [1:0]       second_bank_outputs,
  output logic [7:0]       cap_array_code,
  output logic             valid_reference,
  output rfm_status_t      status
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic rfm_ratio_t ratio_of(input logic [1:0] code);
    rfm_ratio_t r;
    r = '{num: 3'h0, den: 2'h0};
    unique case (code)
      `RFM_SEL_HALF:   r = '{num: `RFM_NUM_HALF,   den: `RFM_DEN_HALF};
      `RFM_SEL_DOUBLE: r = '{num: `RFM_NUM_DOUBLE, den: `RFM_DEN_DOUBLE};
      `RFM_SEL_SIX:    r = '{num: `RFM_NUM_SIX,    den: `RFM_DEN_SIX};
      `RFM_SEL_BYPASS: r = '{num: 3'h0,            den: 2'h0};
    endcase
    return r;
  endfunction

  // One cycle of slack covers the counting error of a single period
  function automatic logic in_band(input logic [18:0] a, input logic [18:0] b);
    logic [18:0] diff;
    logic [47:0] lhs;
    logic [47:0] rhs;
    diff = (a > b) ? (a - b) : (b - a);
    lhs  = 48'(diff) * 48'(`RFM_PPM_SCALE);
    rhs  = 48'(b) * 48'(`RFM_CAPTURE_PPM) + 48'(`RFM_PPM_SCALE);
    return lhs <= rhs;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] cfg_a;
  logic [2:0] cfg_b;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      cfg_a <= 3'h0;
      cfg_b <= 3'h0;
    end
    else
    begin
      cfg_a <= {reference_select, ratio_select};
      cfg_b <= cfg_a;
    end
  end

  logic       sel_first;
  logic [1:0] ratio_code;
  logic       bypass;
  rfm_ratio_t ratio;

  assign sel_first  = cfg_b[2];
  assign ratio_code = cfg_b[1:0];
  assign bypass     = (ratio_code == `RFM_SEL_BYPASS);
  assign ratio      = ratio_of(ratio_code);

  // ****************************************************************
  // Clock routing
  // ****************************************************************
  logic selected_ref;

  assign selected_ref     = sel_first ? ref_first : ref_second;
  // The loop never sees a reference, so reselecting cannot glitch it
  assign loop_input_clock = crystal_input;
  // Bypass changes are rare strap-like events; a runt pulse on change is accepted
  assign first_bank_outputs  = bypass ? {2{selected_ref}} : {2{loop_clock}};
  assign second_bank_outputs = bypass ? {2{selected_ref}} : {2{loop_clock}};

  // ****************************************************************
  // Measurement
  // ****************************************************************
  rfm_meter_t ref_m;
  rfm_meter_t xtl_m;
  rfm_meter_t fbk_m;

  rfm_edge_meter u_ref_meter (.sys_clk(sys_clk), .nrst(nrst), .pin_in(selected_ref),
                              .meter(ref_m));
  rfm_edge_meter u_xtl_meter (.sys_clk(sys_clk), .nrst(nrst), .pin_in(crystal_input),
                              .meter(xtl_m));
  rfm_edge_meter u_fbk_meter (.sys_clk(sys_clk), .nrst(nrst), .pin_in(feedback_input),
                              .meter(fbk_m));

  logic [18:0] ref_scaled;
  logic [18:0] xtl_scaled;
  logic [18:0] fail_limit;
  logic [23:0] recover_limit;
  logic        xtal_ok;
  logic        ref_lost;
  logic        range_ok;

  assign ref_scaled = 19'(ref_m.period) * 19'(ratio.num);
  assign xtl_scaled = 19'(xtl_m.period) * 19'(ratio.den);
  assign xtal_ok    = (xtl_m.period != 16'h0000) && (32'(xtl_m.gap) < XTAL_TIMEOUT);
  // The crystal period equals the reference period times the ratio
  assign fail_limit = bypass ? 19'(BYPASS_TIMEOUT)
                    : 19'(xtl_m.period) * 19'(`RFM_FAIL_PERIODS)
                      + 19'(`RFM_FAIL_EXTRA_CYC);
  assign recover_limit = 24'(xtl_m.period) * 24'(`RFM_RECOVER_PERIODS)
                       + 24'(`RFM_REC_EXTRA_CYC);
  assign ref_lost = (19'(ref_m.gap) >= fail_limit) || (!bypass && !xtal_ok);
  assign range_ok = bypass || in_band(ref_scaled, xtl_scaled);

  // ****************************************************************
  // Reference quality and valid flag
  // ****************************************************************
  rfm_state_t  state;
  rfm_state_t  next_state;
  logic        ref_good;
  logic        next_ref_good;
  logic [23:0] hold_cnt;
  logic [23:0] next_hold_cnt;
  logic        next_valid;

  always_comb
  begin
    next_ref_good = ref_good;
    if (ref_lost)
      next_ref_good = 1'b0;
    else if (ref_m.edge_seen && ref_m.period != 16'h0000)
      next_ref_good = range_ok;
  end

  always_comb
  begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    unique case (state)
      RFM_FAIL:
      begin
        next_hold_cnt = 24'h000000;
        if (ref_good)
          next_state = RFM_RECOVER;
      end
      RFM_RECOVER:
      begin
        if (!ref_good)
          next_state = RFM_FAIL;
        else if (hold_cnt >= recover_limit)
          next_state = RFM_VALID;
        else
          next_hold_cnt = hold_cnt + 24'h000001;
      end
      RFM_VALID:
      begin
        if (!ref_good)
          next_state = RFM_FAIL;
      end
    endcase
    next_valid = (next_state == RFM_VALID);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ref_good        <= 1'b0;
      state           <= RFM_FAIL;
      hold_cnt        <= 24'h000000;
      valid_reference <= 1'b0;
    end
    else
    begin
      ref_good        <= next_ref_good;
      state           <= next_state;
      hold_cnt        <= next_hold_cnt;
      valid_reference <= next_valid;
    end
  end

  // ****************************************************************
  // Capacitor array tuning
  // ****************************************************************
  logic       tracking;
  logic       step_up;
  logic       step_down;
  logic [7:0] next_code;

  // Frozen in bypass and whenever the reference is bad
  assign tracking = !bypass && ref_good && !ref_lost;
  always_comb
  begin
    step_up   = 1'b0;
    step_down = 1'b0;
    // A larger code raises the crystal frequency
    if (xtl_scaled > ref_scaled)
      step_up = 1'b1;
    else if (xtl_scaled < ref_scaled)
      step_down = 1'b1;
    else if (fbk_m.gap > (ref_m.period >> 1))
      step_up = 1'b1;   // Feedback lags the reference edge
    else if (fbk_m.gap != 16'h0000)
      step_down = 1'b1;
    next_code = cap_array_code;
    if (tracking && ref_m.edge_seen)
    begin
      if (step_up && cap_array_code != `RFM_TUNE_MAX)
        next_code = cap_array_code + 8'h01;
      else if (step_down && cap_array_code != `RFM_TUNE_MIN)
        next_code = cap_array_code - 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      cap_array_code <= `RFM_TUNE_RESET;
    else
      cap_array_code <= next_code;
  end

  assign status = '{bypass: bypass, tracking: tracking, ref_good: ref_good, xtal_ok: xtal_ok};

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_flag_tracks_state: assert property (@(posedge sys_clk) disable iff (!nrst)
    valid_reference == (state == RFM_VALID))
    else $error("valid flag disagrees with state");
  a_lost_drops_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
    ref_lost |-> ##2 !valid_reference)
    else $error("flag still high two cycles after loss");
  a_out_of_range_fails: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ref_m.edge_seen && ref_m.period != 16'h0000 && !range_ok && !ref_lost)
      |=> !ref_good ##1 !valid_reference)
    else $error("out of range reference not flagged");
  a_hold_before_valid: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(valid_reference) |-> $past(hold_cnt) >= $past(recover_limit))
    else $error("valid asserted before recovery hold");
  a_freeze_on_loss: assert property (@(posedge sys_clk) disable iff (!nrst)
    !tracking |=> $stable(cap_array_code))
    else $error("tuning moved while not tracking");
  a_bypass_outputs: assert property (@(posedge sys_clk) disable iff (!nrst)
    bypass |-> first_bank_outputs == {2{selected_ref}}
               && second_bank_outputs == {2{selected_ref}})
    else $error("bypass outputs not from reference");
  a_bypass_no_tune: assert property (@(posedge sys_clk) disable iff (!nrst)
    bypass |-> !tracking)
    else $error("tuning active in bypass");
  a_loop_crystal: assert property (@(posedge sys_clk) disable iff (!nrst)
    loop_input_clock == crystal_input)
    else $error("loop input not the crystal");
  a_select_route: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst, 2)
      |-> selected_ref == ($past(reference_select, 2) ? ref_first : ref_second))
    else $error("wrong reference routed");
  a_tune_step_one: assert property (@(posedge sys_clk) disable iff (!nrst)
    (tracking && ref_m.edge_seen && step_up && cap_array_code != `RFM_TUNE_MAX)
      |=> cap_array_code == $past(cap_array_code) + 8'h01)
    else $error("tuning step missing");

  c_recover: cover property (@(posedge sys_clk) disable iff (!nrst)
    state == RFM_RECOVER ##1 state == RFM_VALID);
  c_fail: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(valid_reference));
  c_tune: cover property (@(posedge sys_clk) disable iff (!nrst) $changed(cap_array_code));
  c_bypass: cover property (@(posedge sys_clk) disable iff (!nrst) bypass && valid_reference);

endmodule // rfm_monitor

`default_nettype wire

// File: dv/rfm_clk_src.sv
// Far-side model: reference sources, crystal, ideal analog loop, feedback wiring.
// Assumes the bench sets periods in ns, each an even number.
`timescale 1ns/1ps
`default_nettype none

module rfm_clk_src
  import rfm_pkg::*;
(
  input  var int          ref1_ns,
  input  var int          ref2_ns,
  input  var int          xtal_ns,
  input  wire logic       ref1_on,
  input  wire logic       ref2_on,
  input  wire logic       reference_select,
  input  wire logic [1:0] bank_out,
  output logic            ref_first,
  output logic            ref_second,
  output logic            crystal_input,
  output logic            loop_clock,
  output logic            feedback_input
);
  initial
  begin
    ref_first     = 1'b0;
    ref_second    = 1'b0;
    crystal_input = 1'b0;
  end

  // A stopped source drives its pin low
  // A stop ends the wave at the end of the current half period, so no late rising edge follows it
  always
  begin
    if (ref1_on)
    begin
      #(ref1_ns / 2);
      if (ref1_on)
        ref_first = ~ref_first;
    end
    else
    begin
      ref_first = 1'b0;
      @(posedge ref1_on);
      #3;   // Keeps pin edges clear of the sys_clk sampling edge
    end
  end

  always
  begin
    if (ref2_on)
    begin
      #(ref2_ns / 2);
      if (ref2_on)
        ref_second = ~ref_second;
    end
    else
    begin
      ref_second = 1'b0;
      @(posedge ref2_on);
      #3;   // Keeps pin edges clear of the sys_clk sampling edge
    end
  end

  // Waits for a period to be set so a zero period cannot spin at time zero
  always
  begin
    if (xtal_ns > 0)
      #(xtal_ns / 2) crystal_input = ~crystal_input;
    else
      #1;
  end

  // Ideal lock: loop output follows the chosen reference, no drift modelled
  assign loop_clock     = reference_select ? ref_first : ref_second;
  assign feedback_input = bank_out[0];
endmodule // rfm_clk_src

`default_nettype wire

// File: dv/tb_reference_failover_monitor.sv
// Self-checking bench of rfm_monitor with a far-side clock model.
// Assumes rfm_pkg and rfm_clk_src are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_reference_failover_monitor
  import rfm_pkg::*;
;
  localparam int XTAL = 240;
  localparam int WATCH_NS = 400000;

  logic        sys_clk, nrst, ref_first, ref_second, reference_select;
  logic        crystal_input, feedback_input, loop_clock, loop_input_clock;
  logic        valid_reference, ref1_on, ref2_on;
  logic [1:0]  ratio_select, first_bank_outputs, second_bank_outputs;
  logic [7:0]  cap_array_code;
  rfm_status_t status;
  int          ref1_ns, ref2_ns, xtal_ns, errors, n_checks;
  logic [31:0] seed;

  rfm_monitor #(.XTAL_TIMEOUT(64), .BYPASS_TIMEOUT(1024)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .ref_first(ref_first), .ref_second(ref_second),
    .reference_select(reference_select), .ratio_select(ratio_select),
    .crystal_input(crystal_input), .feedback_input(feedback_input),
    .loop_clock(loop_clock), .loop_input_clock(loop_input_clock),
    .first_bank_outputs(first_bank_outputs), .second_bank_outputs(second_bank_outputs),
    .cap_array_code(cap_array_code), .valid_reference(valid_reference), .status(status));

  rfm_clk_src i_src (
    .ref1_ns(ref1_ns), .ref2_ns(ref2_ns), .xtal_ns(xtal_ns), .ref1_on(ref1_on),
    .ref2_on(ref2_on), .reference_select(reference_select), .bank_out(first_bank_outputs),
    .ref_first(ref_first), .ref_second(ref_second), .crystal_input(crystal_input),
    .loop_clock(loop_clock), .feedback_input(feedback_input));

  // ****************************************************************
  // Reference model and helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected bank pins: bypass passes the chosen reference, tuned passes the loop
  function automatic logic [7:0] exp_bank(input logic [1:0] code, input logic sel);
    logic b;
    b = (code == 2'h0) ? (sel ? ref_first : ref_second) : loop_clock;
    return {6'h00, b, b};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_valid(input logic want, input int lim, output int cyc);
    cyc = 0;
    while (valid_reference !== want && cyc < lim)
    begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic run_bypass();
    logic s;
    int   c;
    @(posedge sys_clk);
    ratio_select <= 2'h0;
    ref1_ns = 60;
    ref2_ns = 100;
    ref1_on <= 1'b1;
    ref2_on <= 1'b1;
    repeat (40)
    begin
      s = 1'(xs());
      @(posedge sys_clk);
      reference_select <= s;
      repeat (3 + xs() % 5) @(posedge sys_clk);
      #2;
      chk("first bank", exp_bank(2'h0, s), 8'(first_bank_outputs));
      chk("second bank", exp_bank(2'h0, s), 8'(second_bank_outputs));
      chk("loop input", 8'(crystal_input), 8'(loop_input_clock));
    end
    chk("bypass tuning", 8'h80, cap_array_code);
    chk("bypass status", 8'h1, 8'(status.bypass));
    ref1_on <= 1'b0;
    ref2_on <= 1'b0;
    wait_valid(1'b0, 1500, c);
    chk("bypass loss", 8'h0, 8'(valid_reference));
    $display("test bypass done");
  endtask

  task automatic run_tuned(input logic [1:0] code, input int rns, input logic drift);
    int         c;
    logic [7:0] cap;
    @(posedge sys_clk);
    ratio_select <= code;
    reference_select <= 1'b1;
    ref1_ns = rns;
    ref1_on <= 1'b1;
    wait_valid(1'b1, 1500, c);
    chk("valid after lock", 8'h1, 8'(valid_reference));
    chk("recover hold", 8'h1, 8'(c * 10 >= 12 * XTAL + 25));
    chk("tuned status", 8'h0, 8'(status.bypass));
    chk("tracking", 8'h1, 8'(status.tracking));
    chk("crystal seen", 8'h1, 8'(status.xtal_ok));
    repeat (4)
    begin
      @(posedge sys_clk);
      #2;
      chk("tuned bank", exp_bank(code, 1'b1), 8'(first_bank_outputs));
      chk("tuned second bank", exp_bank(code, 1'b1), 8'(second_bank_outputs));
    end
    if (drift)
    begin
      ref1_ns = 200;
      wait_valid(1'b0, 200, c);
      chk("out of range", 8'h0, 8'(valid_reference));
      chk("no tracking", 8'h0, 8'(status.tracking));
      cap = cap_array_code;
      repeat (300) @(posedge sys_clk);
      chk("no tuning out of range", cap, cap_array_code);
      chk("still failed", 8'h0, 8'(valid_reference));
      ref1_ns = rns;
      wait_valid(1'b1, 1500, c);
      chk("back in range", 8'h1, 8'(valid_reference));
    end
    @(posedge sys_clk);
    ref1_on <= 1'b0;
    wait_valid(1'b0, 200, c);
    cap = cap_array_code;
    // Sync and answer latency of about 7 cycles sits on top of the pin bound
    chk("fail delay", 8'h1, 8'(c * 10 <= 2 * XTAL + 25 + 70));
    repeat (100) @(posedge sys_clk);
    chk("frozen tuning", cap, cap_array_code);
    $display("test tuned code %0d done", code);
  endtask

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    seed = 32'd79196;
    errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    reference_select = 1'b0;
    ratio_select = 2'h0;
    ref1_on = 1'b0;
    ref2_on = 1'b0;
    ref1_ns = 60;
    ref2_ns = 100;
    xtal_ns = XTAL;
    repeat (12) @(posedge sys_clk);
    #1;
    chk("reset flag", 8'h0, 8'(valid_reference));
    chk("reset tuning", 8'h80, cap_array_code);
    chk("reset ref good", 8'h0, 8'(status.ref_good));
    @(posedge sys_clk);
    nrst <= 1'b1;
    $display("test reset done");
    run_bypass();
    // Ratios 1/2, 2 and 6 give reference periods 2, 1/2 and 1/6 of the crystal's
    run_tuned(2'h1, 2 * XTAL, 1'b0);
    run_tuned(2'h2, XTAL / 2, 1'b1);
    run_tuned(2'h3, XTAL / 6, 1'b0);
    end_of_test();
  end

  initial
  begin
    #(WATCH_NS);
    errors++;
    end_of_test();
  end
endmodule // tb_reference_failover_monitor

`default_nettype wire
